// >>> ccd_startup_cfg.svh
/*
  Offsets, field positions, reset values and timing counts for the
  front-end start-up, standby and restart controller.
  Assumes it is included by its bare name wherever these are needed.
*/
`ifndef CCD_STARTUP_CFG_SVH
`define CCD_STARTUP_CFG_SVH

// ==========================================================
// Serial word layout
`define ADDR_BITS 12
`define DATA_BITS 28
`define ADDR_CNT_LAST 5'h0b
`define DATA_CNT_LAST 5'h1b

// ==========================================================
// Register offsets
`define REG_POWER 12'h000
`define REG_FORMAT 12'h001
`define REG_SOFT_RESET 12'h010
`define REG_OUT_ENABLE 12'h011
`define REG_CORE_RESTART 12'h014

// ==========================================================
// Field positions
`define STANDBY_LSB 0
`define STANDBY_MSB 1
`define REFBUF_BIT 2
`define GRAY_BIT 2
`define SRST_BIT 0
`define OE_BIT 0
`define RESTART_BIT 0

// ==========================================================
// Reset values
`define STANDBY_RST 2'h3
`define REFBUF_PD_RST 1'h1
`define GRAY_RST 1'h0
`define OE_RST 1'h0
`define RESTART_RST 1'h0

// ==========================================================
// Output levels and timing
`define DOUT_W 14
`define NUM_HCLK 6
`define HCLK_IDLE 6'h0a
`define HRST_DELAY 4'hc
`define HRST_LATE_EXTRA 4'h1

`endif

// >>> ccd_startup_pkg.sv
/*
  Types for the front-end start-up, standby and restart controller.
  Assumes ccd_startup_cfg.svh is on the include path.
*/
`include "ccd_startup_cfg.svh"

package ccd_startup_pkg;

  // ==========================================================
  // Enumerations
  typedef enum logic {
    SER_ADDR,
    SER_DATA
  } ser_phase_e;

  typedef enum logic [1:0] {
    PM_NORMAL,
    PM_REF_STANDBY,
    PM_SHUTDOWN
  } power_mode_e;

  // ==========================================================
  // Clock driver group: level and enable per driver.
  typedef struct packed {
    logic [`NUM_HCLK-1:0] level;
    logic [`NUM_HCLK-1:0] oe;
  } drive_s;

  // ==========================================================
  // Whole state of the controller.
  typedef struct packed {
    logic sck_s1;
    logic sck_s2;
    logic sck_s3;
    logic sdi_s1;
    logic sdi_s2;
    logic sl_n_s1;
    logic sl_n_s2;
    logic vd_s1;
    logic vd_s2;
    logic vd_s3;
    logic hd_s1;
    logic hd_s2;
    logic hd_s3;
    ser_phase_e phase;
    logic [4:0] bitcnt;
    logic [`DATA_BITS-1:0] shreg;
    logic [`ADDR_BITS-1:0] addr;
    logic [1:0] standby;
    logic refbuf_pd;
    logic gray_pend;
    logic gray_act;
    logic oe_pend;
    logic oe_act;
    logic restart;
    logic srst_pend;
    logic [3:0] hdly;
    logic hdly_run;
    logic hrst;
    logic core_rst;
    logic core_on;
    logic afe_on;
    logic afe_ref_only;
    logic refbuf_on;
    logic phase_tgl;
    drive_s drv;
    logic [`DOUT_W-1:0] dout;
  } state_s;

endpackage : ccd_startup_pkg

// >>> ccd_startup_ctrl.sv
/*
  Start-up, standby and restart controller of a CCD front end.

  Holds: the three-wire serial register port with address
  auto-increment, the self-clearing soft reset, the standby field and
  reference buffer power-down, the timing-core restart pulse, output
  enable and gray coding that wait for the next sync falling edge, the
  drive levels of the horizontal and reset-gate clocks in every power
  mode, and the horizontal counter reset after a horizontal sync fall.

  Assumes of its surroundings:
  - sys_clk is the master clock; rst is asynchronous and active high.
  - serial_clock, serial_data, serial_load_n and both syncs are
    asynchronous to sys_clk and pass two flip-flops before use.
  - Each half period of serial_clock lasts at least three sys_clk
    cycles, or a bit is missed.
  - The serial clock stands still while serial_load_n is high.
  - adc_sample and data_sample_late come from logic on sys_clk.
  - The pads turn each level and drive enable pair into a three-state
    driver; a low enable leaves the pin high-impedance.
*/
// Notes on behaviour
// - Soft reset write restores defaults, self-clears.
// - Restart write resets and starts timing core.
// - Output enable applies at next sync fall.
// - Horizontal counter resets 12 cycles after fall.
// - Late sample position adds one cycle.
// - Standby field selects normal, reference, shutdown.
// - Shutdown beats enable; reference standby beats enable.
// - Bit 2 powers down reference buffer independently.
// - Shutdown: clocks high-impedance, data low, core off.
// - Shutdown default; enable low gives idle levels.
// - Reference standby: references on, idle levels.
// - Format bit 2 selects gray-coded data.
// - 12-bit address, 28-bit data, LSB first.
// - Deferred registers load at vertical or horizontal fall.
`timescale 1ns/1ps
`include "ccd_startup_cfg.svh"

module ccd_startup_ctrl #(
  parameter logic [3:0] HRST_DELAY = `HRST_DELAY
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic serial_load_n,
  input wire logic vertical_sync,
  input wire logic horizontal_sync,
  input wire logic data_sample_late,
  input wire logic [`DOUT_W-1:0] adc_sample,
  output logic horizontal_ccd_clock_one,
  output logic horizontal_ccd_clock_one_oe,
  output logic horizontal_ccd_clock_two,
  output logic horizontal_ccd_clock_two_oe,
  output logic horizontal_ccd_clock_three,
  output logic horizontal_ccd_clock_three_oe,
  output logic horizontal_ccd_clock_four,
  output logic horizontal_ccd_clock_four_oe,
  output logic last_stage_horizontal_clock,
  output logic last_stage_horizontal_clock_oe,
  output logic reset_gate_clock,
  output logic reset_gate_clock_oe,
  output logic [`DOUT_W-1:0] pixel_data,
  output logic horizontal_counter_reset,
  output logic timing_core_reset,
  output logic timing_core_enable,
  output logic analog_front_end_power,
  output logic analog_front_end_ref_only,
  output logic reference_buffer_enable
);

  // ==========================================================
  // State
  // Every flop of the block sits in this one packed struct.
  ccd_startup_pkg::state_s q;
  ccd_startup_pkg::state_s d;

  logic sck_rise;
  logic vd_fall;
  logic hd_fall;
  logic word_done;
  logic [`DATA_BITS-1:0] word;
  ccd_startup_pkg::power_mode_e mode;

  // ==========================================================
  // Edge detect on the synchronised pins. The third flop of the clock and sync chains
  // only remembers the previous level; only the second flop reads the first.
  assign sck_rise = q.sck_s2 & ~q.sck_s3;
  assign vd_fall = ~q.vd_s2 & q.vd_s3;
  assign hd_fall = ~q.hd_s2 & q.hd_s3;
  assign word = {q.sdi_s2, q.shreg[`DATA_BITS-1:1]};
  assign word_done = sck_rise & ~q.sl_n_s2 & (q.phase == ccd_startup_pkg::SER_DATA) &
                     (q.bitcnt == `DATA_CNT_LAST);

  // ==========================================================
  // Power mode decode
  always_comb begin
    // Both codes with the top bit set shut the device down.
    case (q.standby)
      2'h0: mode = ccd_startup_pkg::PM_NORMAL;
      2'h1: mode = ccd_startup_pkg::PM_REF_STANDBY;
      default: mode = ccd_startup_pkg::PM_SHUTDOWN;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    // Two flops guard against metastability; a third serves the edge detect.
    d.sck_s1 = serial_clock;
    d.sck_s2 = q.sck_s1;
    d.sck_s3 = q.sck_s2;
    d.sdi_s1 = serial_data;
    d.sdi_s2 = q.sdi_s1;
    d.sl_n_s1 = serial_load_n;
    d.sl_n_s2 = q.sl_n_s1;
    d.vd_s1 = vertical_sync;
    d.vd_s2 = q.vd_s1;
    d.vd_s3 = q.vd_s2;
    d.hd_s1 = horizontal_sync;
    d.hd_s2 = q.hd_s1;
    d.hd_s3 = q.hd_s2;
    d.core_rst = 1'b0;
    d.hrst = 1'b0;

    // Serial shifter. Raising the load line abandons a partial word,
    // so a short word never reaches a register.
    // Bits enter at the top, so the first bit sent ends up at bit 0.
    if (q.sl_n_s2) begin
      d.phase = ccd_startup_pkg::SER_ADDR;
      d.bitcnt = 5'h00;
    end else if (sck_rise) begin
      d.shreg = word;
      d.bitcnt = q.bitcnt + 5'h01;
      case (q.phase)
        ccd_startup_pkg::SER_ADDR: begin
          // The twelfth bit completes the address; data words follow.
          if (q.bitcnt == `ADDR_CNT_LAST) begin
            d.addr = word[`DATA_BITS-1 -: `ADDR_BITS];
            d.phase = ccd_startup_pkg::SER_DATA;
            d.bitcnt = 5'h00;
          end
        end
        ccd_startup_pkg::SER_DATA: begin
          if (q.bitcnt == `DATA_CNT_LAST) begin
            d.addr = q.addr + 12'h001;
            d.bitcnt = 5'h00;
          end
        end
        default: begin
          d.phase = ccd_startup_pkg::SER_ADDR;
        end
      endcase
    end

    // Register writes take effect on the last data bit; output enable and
    // format wait in a pending copy.
    if (word_done) begin
      case (q.addr)
        `REG_POWER: begin
          d.standby = word[`STANDBY_MSB:`STANDBY_LSB];
          d.refbuf_pd = word[`REFBUF_BIT];
        end
        `REG_FORMAT: d.gray_pend = word[`GRAY_BIT];
        `REG_SOFT_RESET: d.srst_pend = word[`SRST_BIT];
        `REG_OUT_ENABLE: d.oe_pend = word[`OE_BIT];
        `REG_CORE_RESTART: begin
          d.restart = word[`RESTART_BIT];
          d.core_rst = word[`RESTART_BIT];
        end
        default: begin
          // Unmapped addresses leave every register as it was.
        end
      endcase
    end

    // Deferred registers load at the next sync falling edge.
    // A write that lands after a fall waits for the following one.
    if (vd_fall | hd_fall) begin
      d.oe_act = q.oe_pend;
      d.gray_act = q.gray_pend;
    end

    // The soft reset acts the cycle after its write and clears itself,
    // long before the next 28-bit word can complete.
    // Serial position and address are kept, so the next word of the same
    // frame still lands at the following address.
    if (q.srst_pend) begin
      d.srst_pend = 1'b0;
      d.standby = `STANDBY_RST;
      d.refbuf_pd = `REFBUF_PD_RST;
      d.gray_pend = `GRAY_RST;
      d.gray_act = `GRAY_RST;
      d.oe_pend = `OE_RST;
      d.oe_act = `OE_RST;
      d.restart = `RESTART_RST;
    end

    // Horizontal counter reset. A later sample position costs one more
    // cycle of pipeline.
    // The count starts at the detected fall, so the synchroniser cycles
    // come on top of it; a new fall restarts the count.
    if (hd_fall) begin
      d.hdly = HRST_DELAY - 4'h1 + (data_sample_late ? `HRST_LATE_EXTRA : 4'h0);
      d.hdly_run = 1'b1;
    end else if (q.hdly_run) begin
      d.hdly = q.hdly - 4'h1;
      if (q.hdly == 4'h1) begin
        d.hrst = 1'b1;
        d.hdly_run = 1'b0;
      end
    end

    // Timing core runs once restarted and not shut down.
    // The toggle only runs with the core, so otherwise the drivers rest at idle.
    d.core_on = q.restart & (mode != ccd_startup_pkg::PM_SHUTDOWN);
    d.phase_tgl = d.core_on & ~q.phase_tgl;
    d.afe_on = (mode == ccd_startup_pkg::PM_NORMAL);
    d.afe_ref_only = (mode == ccd_startup_pkg::PM_REF_STANDBY);
    d.refbuf_on = ~q.refbuf_pd & (mode != ccd_startup_pkg::PM_SHUTDOWN);

    // Output states: shutdown first, then low enable or reference standby alike, then toggling.
    // A low enable in shutdown leaves the pins to the high-impedance pads.
    if (mode == ccd_startup_pkg::PM_SHUTDOWN) begin
      d.drv.level = `HCLK_IDLE;
      d.drv.oe = '0;
      d.dout = '0;
    end else if (!q.oe_act || mode == ccd_startup_pkg::PM_REF_STANDBY) begin
      d.drv.level = `HCLK_IDLE;
      d.drv.oe = '1;
      d.dout = '0;
    end else begin
      d.drv.level = `HCLK_IDLE ^ {`NUM_HCLK{q.phase_tgl & q.core_on}};
      d.drv.oe = '1;
      // Gray code flips one bit between neighbouring codes, which keeps
      // switching noise on the data pins down.
      if (q.gray_act) begin
        d.dout = adc_sample ^ (adc_sample >> 1);
      end else begin
        d.dout = adc_sample;
      end
    end
  end

  // ==========================================================
  // Registers
  // Reset puts every synchroniser at the idle level of its pin, so no
  // false edge follows the release of reset.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.sck_s1 <= 1'b0;
      q.sl_n_s1 <= 1'b1;
      q.sl_n_s2 <= 1'b1;
      q.vd_s1 <= 1'b1;
      q.vd_s2 <= 1'b1;
      q.vd_s3 <= 1'b1;
      q.hd_s1 <= 1'b1;
      q.hd_s2 <= 1'b1;
      q.hd_s3 <= 1'b1;
      q.phase <= ccd_startup_pkg::SER_ADDR;
      q.standby <= `STANDBY_RST;
      q.refbuf_pd <= `REFBUF_PD_RST;
      q.drv.level <= `HCLK_IDLE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs, straight from the state flops
  assign horizontal_ccd_clock_one = q.drv.level[0];
  assign horizontal_ccd_clock_one_oe = q.drv.oe[0];
  assign horizontal_ccd_clock_two = q.drv.level[1];
  assign horizontal_ccd_clock_two_oe = q.drv.oe[1];
  assign horizontal_ccd_clock_three = q.drv.level[2];
  assign horizontal_ccd_clock_three_oe = q.drv.oe[2];
  assign horizontal_ccd_clock_four = q.drv.level[3];
  assign horizontal_ccd_clock_four_oe = q.drv.oe[3];
  assign last_stage_horizontal_clock = q.drv.level[4];
  assign last_stage_horizontal_clock_oe = q.drv.oe[4];
  assign reset_gate_clock = q.drv.level[5];
  assign reset_gate_clock_oe = q.drv.oe[5];
  assign pixel_data = q.dout;
  assign horizontal_counter_reset = q.hrst;
  assign timing_core_reset = q.core_rst;
  assign timing_core_enable = q.core_on;
  assign analog_front_end_power = q.afe_on;
  assign analog_front_end_ref_only = q.afe_ref_only;
  assign reference_buffer_enable = q.refbuf_on;

endmodule : ccd_startup_ctrl

// >>> ccd_startup_ctrl_guard_unused.sv
/*
  Spare source slot of the start-up controller.
  Holds no logic: the controller module of the block lives in ccd_startup_ctrl.sv.
*/

// >>> ccd_startup_ctrl_monitor.sv
/*
  Port checker for the start-up controller: power modes, drive states,
  restart pulses and the horizontal counter reset after a sync fall.
  Assumes it is bound into ccd_startup_ctrl and the cfg header is on the path.
*/
`timescale 1ns/1ps
`include "ccd_startup_cfg.svh"

module ccd_startup_ctrl_monitor #(
  parameter logic [3:0] HRST_DELAY = `HRST_DELAY
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic horizontal_sync,
  input wire logic data_sample_late,
  input wire logic horizontal_ccd_clock_one,
  input wire logic horizontal_ccd_clock_two,
  input wire logic horizontal_ccd_clock_one_oe,
  input wire logic [`DOUT_W-1:0] pixel_data,
  input wire logic horizontal_counter_reset,
  input wire logic timing_core_reset,
  input wire logic timing_core_enable,
  input wire logic analog_front_end_power,
  input wire logic analog_front_end_ref_only,
  input wire logic reference_buffer_enable
);
  localparam int D = HRST_DELAY;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire shut = !analog_front_end_power && !analog_front_end_ref_only;
  logic hd_q, late_q, seen_q;
  logic [7:0] cnt_q;

  // ==========================================================
  // Cycle count since the sync pin fell; the window allows for the synchroniser.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hd_q <= 1'b1;
      late_q <= 1'b0;
      seen_q <= 1'b1;
      cnt_q <= 8'hff;
    end else begin
      hd_q <= horizontal_sync;
      if (hd_q && !horizontal_sync) begin
        cnt_q <= 8'h01;
        late_q <= data_sample_late;
        seen_q <= 1'b0;
      end else begin
        if (cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
        if (horizontal_counter_reset) seen_q <= 1'b1;
      end
    end
  end

  sequence shut_s;
    shut [*3];
  endsequence
  sequence ref_s;
    analog_front_end_ref_only [*3];
  endsequence

  // ==========================================================
  // Assertions
  chk_hrst_window: assert property (horizontal_counter_reset |->
    cnt_q >= D + 1 + late_q && cnt_q <= D + 4 + late_q)
    else $error("counter reset outside its window after sync fall");
  chk_hrst_missing: assert property (cnt_q == D + 5 + late_q |-> seen_q)
    else $error("counter reset missing after sync fall");
  chk_shut_hiz: assert property (shut_s |-> !horizontal_ccd_clock_one_oe && pixel_data == '0)
    else $error("drivers or data active in shutdown");
  chk_shut_core_off: assert property (shut_s |-> !timing_core_enable)
    else $error("timing core on in shutdown");
  chk_mode_exclusive: assert property (!(analog_front_end_power && analog_front_end_ref_only))
    else $error("two power modes at once");
  chk_ref_idle: assert property (ref_s |-> horizontal_ccd_clock_one_oe &&
    !horizontal_ccd_clock_one && horizontal_ccd_clock_two && pixel_data == '0)
    else $error("reference standby levels wrong");
  chk_refbuf_mode: assert property (reference_buffer_enable |-> !shut)
    else $error("reference buffer on in shutdown");
  chk_restart_enable: assert property (timing_core_reset && analog_front_end_power
    |-> ##[0:2] timing_core_enable)
    else $error("restart did not start the timing core");
  chk_reset_defaults: assert property ($fell(rst) |-> shut && !timing_core_enable &&
    !horizontal_ccd_clock_one_oe)
    else $error("state after reset is not shutdown");
endmodule : ccd_startup_ctrl_monitor

bind ccd_startup_ctrl ccd_startup_ctrl_monitor #(.HRST_DELAY(HRST_DELAY)) chk_u (.*);

// >>> ccd_host_model.sv
/*
  Host side of the three-wire serial port: sends address and data words.
  Assumes the caller spaces words; the serial clock stands still between frames.
  Pins change by non-blocking assignment on sys_clk, four cycles a half period.
*/
`timescale 1ns/1ps

module ccd_host_model (
  input wire logic sys_clk,
  output logic serial_clock,
  output logic serial_data,
  output logic serial_load_n
);
  initial begin
    serial_clock = 1'b0;
    serial_data = 1'b0;
    serial_load_n = 1'b1;
  end

  // Fewer than 28 data bits is only used to provoke a dropped word.
  task automatic send(input logic [11:0] a, input logic [27:0] d, input int nd);
    logic [39:0] w;
    w = {d, a};
    @(posedge sys_clk);
    serial_load_n <= 1'b0;
    for (int i = 0; i < 12 + nd; i++) begin
      serial_data <= w[i];
      repeat (4) @(posedge sys_clk);
      serial_clock <= 1'b1;
      repeat (4) @(posedge sys_clk);
      serial_clock <= 1'b0;
    end
    repeat (4) @(posedge sys_clk);
    serial_load_n <= 1'b1;
    serial_data <= ~serial_data;
  endtask : send
endmodule : ccd_host_model

// >>> test_ccd_startup_ctrl.sv
/*
  Self-checking bench: power modes, bring-up, deferred enable, gray data,
  soft reset, dropped words and horizontal counter reset.
  Assumes the host model drives the serial pins and the checker is bound.
*/
`timescale 1ns/1ps
`include "ccd_startup_cfg.svh"
`define CHECK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end

module test_ccd_startup_ctrl;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic vertical_sync = 1'b1;
  logic horizontal_sync = 1'b1;
  logic data_sample_late = 1'b0;
  logic [`DOUT_W-1:0] adc_sample = 14'h2c5;
  logic serial_clock, serial_data, serial_load_n;
  wire [5:0] lvl;
  wire [5:0] oe6;
  logic [5:0] prev;
  logic [`DOUT_W-1:0] pixel_data;
  logic hcr, tcr, tce, afe, refo, rbe;
  int bad_count = 0, check_count = 0, cyc = 0, tcr_n = 0, hcr_n = 0;

  ccd_host_model host_u (.sys_clk(sys_clk), .serial_clock(serial_clock),
    .serial_data(serial_data), .serial_load_n(serial_load_n));
  ccd_startup_ctrl #(.HRST_DELAY(4'hc)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .serial_clock(serial_clock), .serial_data(serial_data), .serial_load_n(serial_load_n),
    .vertical_sync(vertical_sync), .horizontal_sync(horizontal_sync),
    .data_sample_late(data_sample_late), .adc_sample(adc_sample),
    .horizontal_ccd_clock_one(lvl[0]), .horizontal_ccd_clock_one_oe(oe6[0]),
    .horizontal_ccd_clock_two(lvl[1]), .horizontal_ccd_clock_two_oe(oe6[1]),
    .horizontal_ccd_clock_three(lvl[2]), .horizontal_ccd_clock_three_oe(oe6[2]),
    .horizontal_ccd_clock_four(lvl[3]), .horizontal_ccd_clock_four_oe(oe6[3]),
    .last_stage_horizontal_clock(lvl[4]), .last_stage_horizontal_clock_oe(oe6[4]),
    .reset_gate_clock(lvl[5]), .reset_gate_clock_oe(oe6[5]), .pixel_data(pixel_data),
    .horizontal_counter_reset(hcr), .timing_core_reset(tcr), .timing_core_enable(tce),
    .analog_front_end_power(afe), .analog_front_end_ref_only(refo),
    .reference_buffer_enable(rbe));

  initial begin
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  always @(posedge sys_clk) begin
    cyc++;
    if (tcr === 1'b1) tcr_n++;
    if (hcr === 1'b1) hcr_n++;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic wr(input logic [11:0] a, input logic [27:0] d);
    host_u.send(a, d, 28);
    tick(5);
  endtask : wr

  // Outputs expected while the drivers are not toggling.
  task automatic mode_chk(input logic [1:0] sb, input logic pd);
    `CHECK("front end power", sb == 2'h0, afe)
    `CHECK("reference only", sb == 2'h1, refo)
    `CHECK("reference buffer", !pd && !sb[1], rbe)
    `CHECK("drive enables", sb[1] ? 6'h00 : 6'h3f, oe6)
    `CHECK("data low", 14'h0, pixel_data)
    if (!sb[1]) `CHECK("idle levels", `HCLK_IDLE, lvl)
  endtask : mode_chk

  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    tick(4);
    mode_chk(2'h3, 1'b1);
    $display("test reset defaults done");
    for (int v = 0; v < 8; v++) begin
      wr(`REG_POWER, 28'(v));
      mode_chk(v[1:0], v[2]);
    end
    $display("test power modes done");
    wr(`REG_POWER, 28'h0);
    tick(5000);
    wr(`REG_CORE_RESTART, 28'h0);
    wr(`REG_CORE_RESTART, 28'h1);
    `CHECK("restart pulses", 1, tcr_n)
    `CHECK("core enable", 1'b1, tce)
    wr(`REG_OUT_ENABLE, 28'h1);
    `CHECK("levels before sync", `HCLK_IDLE, lvl)
    @(posedge sys_clk) vertical_sync <= 1'b0;
    tick(8);
    prev = lvl;
    tick(1);
    `CHECK("clock toggle", ~prev, lvl)
    `CHECK("binary data", adc_sample, pixel_data)
    wr(`REG_FORMAT, 28'h4);
    `CHECK("data before sync", adc_sample, pixel_data)
    @(posedge sys_clk) horizontal_sync <= 1'b0;
    tick(20);
    `CHECK("gray data", 14'h3a7, pixel_data)
    @(posedge sys_clk) horizontal_sync <= 1'b1;
    data_sample_late <= 1'b1;
    tick(3);
    @(posedge sys_clk) horizontal_sync <= 1'b0;
    tick(20);
    `CHECK("counter reset pulses", 2, hcr_n)
    $display("test bring-up done");
    wr(`REG_POWER, 28'h1);
    mode_chk(2'h1, 1'b0);
    wr(`REG_POWER, 28'h2);
    mode_chk(2'h2, 1'b0);
    $display("test priority done");
    wr(`REG_POWER, 28'h0);
    wr(`REG_SOFT_RESET, 28'h1);
    mode_chk(2'h3, 1'b1);
    `CHECK("core after soft reset", 1'b0, tce)
    host_u.send(`REG_POWER, 28'h0, 27);
    tick(5);
    mode_chk(2'h3, 1'b1);
    wr(`REG_POWER, 28'h1);
    mode_chk(2'h1, 1'b0);
    $display("test soft reset done");
    report_and_stop;
  end
endmodule : test_ccd_startup_ctrl
